// ### src/rsc_startup_config.sv
// start-up wait and automatic calibration configuration
// assumes register accesses come already decoded from the serial port
// and that clk_sys is the crystal clock
`timescale 1ns/10ps
module rsc_startup_config (
   input  wire logic       clk_sys,
   input  wire logic       rst_b,
   input  wire logic [5:0] regAddr,
   input  wire logic       regWrEn,
   input  wire logic [7:0] regWrData,
   input  wire logic       regRdEn,
   output logic      [7:0] regRdData,
   input  wire logic       oscRunning,
   input  wire logic       enterRx,
   input  wire logic       autoRxToIdle,
   input  wire logic       calibrateStrobe,
   input  wire logic       sleepState,
   output logic            calibrateReq,
   output logic            chipReadyLow,
   output logic            oscSettledFlag,
   output logic            keepOscOn
);
   rsc_tick_if tick ();

   rsc_ripple_timer #(
      .CNT_BITS (rsc_pkg::RIPPLE_BITS)
   ) u_ripple (
      .clk_sys (clk_sys),
      .rst_b   (rst_b),
      .tick    (tick)
   );

   // expiry count for a power-on expiry code, used by logic and checks
   function automatic logic [8:0] expiryTarget(input logic [1:0] code);
      case (code)
         2'h0:    expiryTarget = rsc_pkg::EXP_CODE0;
         2'h1:    expiryTarget = rsc_pkg::EXP_CODE1;
         2'h2:    expiryTarget = rsc_pkg::EXP_CODE2;
         default: expiryTarget = rsc_pkg::EXP_CODE3;
      endcase
   endfunction

   // configuration register
   logic [rsc_pkg::CFG_BITS-1:0] cfg_reg;
   logic [rsc_pkg::CFG_BITS-1:0] cfg_next;
   logic [7:0]                   rdData_reg;
   logic [7:0]                   rdData_next;
   logic [1:0]                   autoCalSel;
   logic [1:0]                   powerOnExpirySel;
   logic                         keepOscInSleep;

   assign autoCalSel       = cfg_reg[rsc_pkg::AUTOCAL_MSB:rsc_pkg::AUTOCAL_LSB];
   assign powerOnExpirySel = cfg_reg[rsc_pkg::PO_EXP_MSB:rsc_pkg::PO_EXP_LSB];
   assign keepOscInSleep   = cfg_reg[rsc_pkg::KEEP_OSC_BIT];

   // unused upper bits read as zero; other addresses read zero too
   always_comb begin
      cfg_next    = cfg_reg;
      rdData_next = 8'h00;
      if (regWrEn && regAddr == rsc_pkg::MAIN_SM_CFG0_ADDR) begin
         cfg_next = regWrData[rsc_pkg::CFG_BITS-1:0];
      end
      if (regRdEn && regAddr == rsc_pkg::MAIN_SM_CFG0_ADDR) begin
         rdData_next = {2'h0, cfg_reg};
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         cfg_reg    <= rsc_pkg::MAIN_SM_CFG0_RESET[rsc_pkg::CFG_BITS-1:0];
         rdData_reg <= 8'h00;
      end else begin
         cfg_reg    <= cfg_next;
         rdData_reg <= rdData_next;
      end
   end

   assign regRdData = rdData_reg;

   // automatic calibration
   logic [1:0] returnCnt_reg;
   logic [1:0] returnCnt_next;
   logic       calReq_reg;
   logic       calReq_next;

   // manual strobe always works; automatic modes add their own trigger
   always_comb begin
      returnCnt_next = returnCnt_reg;
      calReq_next    = calibrateStrobe;
      case (autoCalSel)
         rsc_pkg::CAL_NEVER: begin
            returnCnt_next = 2'h0;
         end
         rsc_pkg::CAL_IDLE_TO_RX: begin
            if (enterRx) calReq_next = 1'b1;
         end
         rsc_pkg::CAL_RX_TO_IDLE: begin
            if (autoRxToIdle) calReq_next = 1'b1;
         end
         rsc_pkg::CAL_EVERY_FOURTH: begin
            if (autoRxToIdle) begin
               returnCnt_next = returnCnt_reg + 2'h1;
               if (returnCnt_reg == rsc_pkg::FOURTH_RETURN) calReq_next = 1'b1;
            end
         end
         default: begin
            returnCnt_next = 2'h0;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         returnCnt_reg <= 2'h0;
         calReq_reg    <= 1'b0;
      end else begin
         returnCnt_reg <= returnCnt_next;
         calReq_reg    <= calReq_next;
      end
   end

   assign calibrateReq = calReq_reg;

   // start-up wait
   rsc_pkg::rsc_start_e state_reg;
   rsc_pkg::rsc_start_e state_next;
   logic [8:0]          expCnt_reg;
   logic [8:0]          expCnt_next;
   logic                run_reg;
   logic                run_next;
   logic                readyLow_reg;
   logic                readyLow_next;
   logic                settled_reg;
   logic                settled_next;

   // expirations are counted in crystal cycles, so the delay scales with it
   always_comb begin
      state_next  = state_reg;
      expCnt_next = expCnt_reg;
      run_next    = 1'b0;
      case (state_reg)
         rsc_pkg::ST_OSC_WAIT: begin
            expCnt_next = 9'h000;
            if (oscRunning) begin
               state_next = rsc_pkg::ST_COUNTING;
               run_next   = 1'b1;
            end
         end
         rsc_pkg::ST_COUNTING: begin
            run_next = 1'b1;
            if (!oscRunning) begin
               state_next = rsc_pkg::ST_OSC_WAIT;
               run_next   = 1'b0;
            end else if (tick.expire) begin
               expCnt_next = expCnt_reg + 9'h001;
               if (expCnt_next == expiryTarget(powerOnExpirySel)) begin
                  state_next = rsc_pkg::ST_READY;
                  run_next   = 1'b0;
               end
            end
         end
         rsc_pkg::ST_READY: begin
            if (!oscRunning) state_next = rsc_pkg::ST_OSC_WAIT;
         end
         default: begin
            state_next = rsc_pkg::ST_OSC_WAIT;
         end
      endcase
      // both flags follow one state, so they can never drift apart
      readyLow_next = (state_next != rsc_pkg::ST_READY);
      settled_next  = (state_next == rsc_pkg::ST_READY);
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         state_reg    <= rsc_pkg::ST_OSC_WAIT;
         expCnt_reg   <= 9'h000;
         run_reg      <= 1'b0;
         readyLow_reg <= 1'b1;
         settled_reg  <= 1'b0;
      end else begin
         state_reg    <= state_next;
         expCnt_reg   <= expCnt_next;
         run_reg      <= run_next;
         readyLow_reg <= readyLow_next;
         settled_reg  <= settled_next;
      end
   end

   assign tick.run       = run_reg;
   assign chipReadyLow   = readyLow_reg;
   assign oscSettledFlag = settled_reg;

   // oscillator hold in sleep
   logic keepOsc_reg;
   logic keepOsc_next;

   // outside sleep the oscillator is always wanted
   always_comb begin
      keepOsc_next = !sleepState || keepOscInSleep;
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         keepOsc_reg <= 1'b1;
      end else begin
         keepOsc_reg <= keepOsc_next;
      end
   end

   assign keepOscOn = keepOsc_reg;

   // checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);

   a_cal_rx_entry: assert property (
      autoCalSel == rsc_pkg::CAL_IDLE_TO_RX && enterRx |=> calibrateReq)
      else $error("no calibration on entry to receive");
   a_cal_fourth_return: assert property (
      autoCalSel == rsc_pkg::CAL_EVERY_FOURTH && autoRxToIdle && !calibrateStrobe
      |=> calibrateReq == ($past(returnCnt_reg) == rsc_pkg::FOURTH_RETURN))
      else $error("fourth return calibration wrong");
   a_cal_never_auto: assert property (
      autoCalSel == rsc_pkg::CAL_NEVER && !calibrateStrobe |=> !calibrateReq)
      else $error("calibration without strobe in manual mode");
   a_ready_after_expire: assert property (
      $fell(chipReadyLow) |-> $past(tick.expire) && $past(oscRunning, 2))
      else $error("ready asserted without ripple expiry");
   a_expiry_count_map: assert property (
      $fell(chipReadyLow) |-> expCnt_reg == expiryTarget(powerOnExpirySel))
      else $error("ready after wrong number of expirations");
   a_wait_cycle_bound: assert property (
      $rose(run_reg) && powerOnExpirySel == 2'h0
      |-> ##[1:65] (!chipReadyLow || !oscRunning || powerOnExpirySel != 2'h0))
      else $error("shortest wait not ended within one period");
   a_flags_together: assert property (
      oscSettledFlag == !chipReadyLow)
      else $error("settled flag and ready indication disagree");
   a_keep_osc_sleep: assert property (
      sleepState && !keepOscInSleep |=> !keepOscOn)
      else $error("oscillator held in sleep without keep bit");

   c_ready_reached:   cover property ($fell(chipReadyLow));
   c_fourth_cal:      cover property (autoCalSel == rsc_pkg::CAL_EVERY_FOURTH
                                      && calibrateReq);
   c_osc_lost_ready:  cover property (state_reg == rsc_pkg::ST_READY && !oscRunning);
endmodule

// ### src/rsc_pkg.sv
// constants of the start-up and calibration configuration block
// assumes a single clock derived from the crystal oscillator
package rsc_pkg;

   // register map
   localparam logic [5:0] MAIN_SM_CFG0_ADDR  = 6'h18;
   localparam logic [7:0] MAIN_SM_CFG0_RESET = 8'h04;

   // field layout of the configuration register
   localparam int AUTOCAL_MSB   = 5;
   localparam int AUTOCAL_LSB   = 4;
   localparam int PO_EXP_MSB    = 3;
   localparam int PO_EXP_LSB    = 2;
   localparam int TUNE_BIT      = 1;
   localparam int KEEP_OSC_BIT  = 0;
   localparam int CFG_BITS      = 6;

   // automatic calibration modes
   localparam logic [1:0] CAL_NEVER       = 2'h0;
   localparam logic [1:0] CAL_IDLE_TO_RX  = 2'h1;
   localparam logic [1:0] CAL_RX_TO_IDLE  = 2'h2;
   localparam logic [1:0] CAL_EVERY_FOURTH = 2'h3;
   localparam logic [1:0] FOURTH_RETURN   = 2'h3;

   // expiry counts selected by the power-on expiry field
   localparam int EXP_CNT_W = 9;
   localparam logic [8:0] EXP_CODE0 = 9'h001;
   localparam logic [8:0] EXP_CODE1 = 9'h010;
   localparam logic [8:0] EXP_CODE2 = 9'h040;
   localparam logic [8:0] EXP_CODE3 = 9'h100;

   // width of the ripple counter
   localparam int RIPPLE_BITS = 6;

   typedef enum logic [1:0] {
      ST_OSC_WAIT,
      ST_COUNTING,
      ST_READY
   } rsc_start_e;

endpackage

// ### src/rsc_tick_if.sv
// carrier between the start-up sequencer and its ripple counter
// assumes both ends share clk_sys
`timescale 1ns/10ps
interface rsc_tick_if;
   logic run;     // counter advances while high, clears when low
   logic expire;  // one-cycle pulse each time the counter wraps

   modport sequencer (output run, input expire);
   modport counter   (input run, output expire);
endinterface

// ### src/rsc_ripple_timer.sv
// run-gated counter that pulses once per full wrap
// assumes run is registered by the sequencer
`timescale 1ns/10ps
module rsc_ripple_timer #(
   parameter int CNT_BITS = rsc_pkg::RIPPLE_BITS
) (
   input  wire logic     clk_sys,
   input  wire logic     rst_b,
   rsc_tick_if.counter   tick
);
   localparam logic [CNT_BITS-1:0] CNT_MAX = {CNT_BITS{1'b1}};

   logic [CNT_BITS-1:0] cnt_reg;
   logic [CNT_BITS-1:0] cnt_next;
   logic                expire_reg;
   logic                expire_next;

   // a one-bit counter would leave an empty replication in the increment
   if (CNT_BITS < 2 || CNT_BITS > 16) begin : g_bad_width
      $error("ripple counter width out of range");
   end

   // counter clears while idle so every wait starts from a full period
   always_comb begin
      cnt_next    = '0;
      expire_next = 1'b0;
      if (tick.run) begin
         cnt_next    = cnt_reg + {{(CNT_BITS-1){1'b0}}, 1'b1};
         expire_next = (cnt_reg == CNT_MAX);
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         cnt_reg    <= '0;
         expire_reg <= 1'b0;
      end else begin
         cnt_reg    <= cnt_next;
         expire_reg <= expire_next;
      end
   end

   assign tick.expire = expire_reg;

   // wrap check written for the default six-bit period of 64 cycles
   if (CNT_BITS == rsc_pkg::RIPPLE_BITS) begin : g_wrap_chk
      a_ripple_wrap_period: assert property (
         @(posedge clk_sys) disable iff (!rst_b)
         $rose(tick.run) |-> ##64 (tick.expire || !tick.run))
         else $error("ripple counter did not expire after a full period");
   end
endmodule

// ### sim/rsc_host_model.sv
// host model: drives the decoded register port and the manual calibrate strobe
// assumes every strobe is sampled on the rising edge of clk_sys
`timescale 1ns/10ps
module rsc_host_model (
   input  wire logic       clk_sys,
   output logic      [5:0] regAddr,
   output logic            regWrEn,
   output logic      [7:0] regWrData,
   output logic            regRdEn,
   output logic            calibrateStrobe
);
   // idle lines show inverted last values so stale data never passes for fresh
   initial begin
      regAddr         = 6'h3F;
      regWrEn         = 1'b0;
      regWrData       = 8'hFF;
      regRdEn         = 1'b0;
      calibrateStrobe = 1'b0;
   end

   // one-cycle write strobe, address and data held across the taking edge
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      #1;
      regAddr   = a;
      regWrData = d;
      regWrEn   = 1'b1;
      @(posedge clk_sys);
      #1;
      regWrEn   = 1'b0;
      regAddr   = ~a;
      regWrData = ~d;
   endtask

   // one-cycle read strobe, data is picked up by the bench monitor
   task automatic rd(input logic [5:0] a);
      @(posedge clk_sys);
      #1;
      regAddr = a;
      regRdEn = 1'b1;
      @(posedge clk_sys);
      #1;
      regRdEn = 1'b0;
      regAddr = ~a;
   endtask

   // manual calibration is the only way when auto mode is off
   task automatic strobe();
      @(posedge clk_sys);
      #1;
      calibrateStrobe = 1'b1;
      @(posedge clk_sys);
      #1;
      calibrateStrobe = 1'b0;
   endtask
endmodule

// ### sim/tb_top.sv
// self-checking bench for the start-up and calibration configuration block
// assumes the host model above drives the register port and strobe
`timescale 1ns/10ps
module tb_top;
   logic       clk_sys = 1'b0;
   logic       rst_b = 1'b0;
   logic       oscRunning = 1'b0;
   logic       enterRx = 1'b0;
   logic       autoRxToIdle = 1'b0;
   logic       sleepState = 1'b0;
   logic [5:0] regAddr;
   logic       regWrEn, regRdEn, calibrateStrobe;
   logic [7:0] regWrData, regRdData, d;
   logic       calibrateReq, chipReadyLow, oscSettledFlag, keepOscOn;
   logic       rdSeen = 1'b0;
   logic       evSeen = 1'b0;
   logic       sl, kp;
   logic [1:0] rndKp;
   logic [7:0] rdQ[$];
   logic       calQ[$];
   int         supQ[$];
   int         error_cnt = 0;
   int         compares = 0;
   int         upCnt = 0;
   int         nTab[4] = '{1, 16, 64, 256};
   logic [1:0] modes[4] = '{2'h0, 2'h3, 2'h1, 2'h2};

   always #4 clk_sys = ~clk_sys;

   rsc_startup_config rsc_startup_config_inst (.clk_sys, .rst_b, .regAddr, .regWrEn,
      .regWrData, .regRdEn, .regRdData, .oscRunning, .enterRx, .autoRxToIdle,
      .calibrateStrobe, .sleepState, .calibrateReq, .chipReadyLow, .oscSettledFlag,
      .keepOscOn);
   rsc_host_model rsc_host_model_inst (.clk_sys, .regAddr, .regWrEn, .regWrData,
      .regRdEn, .calibrateStrobe);

   task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
      compares++;
      if (g !== e) begin
         error_cnt++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   task automatic cmp1(input logic g, input logic e);
      cmp8({7'h00, g}, {7'h00, e});
   endtask

   // start-up wait: falling edges seen with oscillator up and ready still high
   task automatic cmpCnt(input int g, input int e);
      compares++;
      if (g !== e) begin
         error_cnt++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   task automatic summarize();
      // a note never matched by a result means the design went quiet
      if (rdQ.size() + calQ.size() + supQ.size() != 0) begin
         error_cnt++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, rdQ.size() + calQ.size() + supQ.size(), 0);
      end
      $display("compares=%0d errors=%0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   task automatic rd(input logic [5:0] a, input logic [7:0] e);
      rdQ.push_back(e);
      rsc_host_model_inst.rd(a);
   endtask

   // kind 0 enters receive, 1 returns to idle, 2 is the manual strobe
   task automatic ev(input int k, input logic e);
      calQ.push_back(e);
      if (k == 2) rsc_host_model_inst.strobe();
      else begin
         @(posedge clk_sys);
         #1;
         if (k == 0) enterRx = 1'b1;
         else autoRxToIdle = 1'b1;
         @(posedge clk_sys);
         #1;
         enterRx = 1'b0;
         autoRxToIdle = 1'b0;
      end
   endtask

   // output monitor: pops the oldest note whenever a result is due
   // falling edge, so every registered output has settled when looked at
   always @(negedge clk_sys) begin
      if (rst_b) begin
         if (rdSeen) cmp8(regRdData, rdQ.pop_front());
         if (evSeen) cmp1(calibrateReq, calQ.pop_front());
         cmp1(oscSettledFlag, ~chipReadyLow);
         if (oscRunning && chipReadyLow) upCnt++;
         else if (!chipReadyLow && upCnt > 0) begin
            cmpCnt(upCnt, supQ.pop_front());
            upCnt = 0;
         end
      end
      rdSeen = regRdEn;
      evSeen = enterRx | autoRxToIdle | calibrateStrobe;
   end

   // watchdog sized well beyond the longest start-up wait
   initial begin
      #(40000 * 8);
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, 0, 1);
      summarize();
   end

   initial begin
      void'($urandom(48261));
      repeat (20) @(posedge clk_sys);
      #1;
      rst_b = 1'b1;
      rd(6'h18, 8'h04);
      d = 8'($urandom);
      rsc_host_model_inst.wr(6'h18, d);
      rd(6'h18, d & 8'h3F);
      rsc_host_model_inst.wr(6'h19, 8'hFF);
      rd(6'h18, d & 8'h3F);
      rd(6'h19, 8'h00);
      $display("registers test done");
      foreach (modes[i]) begin
         rsc_host_model_inst.wr(6'h18, {2'h0, modes[i], 4'h4});
         ev(0, modes[i] == 2'h1);
         for (int j = 0; j < 4; j++) ev(1, modes[i] == 2'h2 || (modes[i] == 2'h3 && j == 3));
         ev(2, 1'b1);
      end
      $display("calibration test done");
      for (int c = 0; c < 4; c++) begin
         // code 2 with the oscillator kept on, as a careful host would
         rsc_host_model_inst.wr(6'h18, {4'h0, c[1:0], 1'b0, c == 2});
         supQ.push_back(nTab[c] * 64 + 2);
         @(posedge clk_sys);
         #1;
         oscRunning = 1'b1;
         for (int k = 0; k < 20000 && chipReadyLow !== 1'b0; k++) @(posedge clk_sys);
         #1;
         oscRunning = 1'b0;
         repeat (2) @(posedge clk_sys);
         #1;
         cmp1(chipReadyLow, 1'b1);
      end
      $display("start-up test done");
      rndKp = 2'($urandom);
      for (int q = 0; q < 4; q++) begin
         // fixed random offset still walks all four sleep and keep pairs
         {sl, kp} = 2'(q) ^ rndKp;
         rsc_host_model_inst.wr(6'h18, {7'h02, kp});
         sleepState = sl;
         repeat (2) @(posedge clk_sys);
         #1;
         cmp1(keepOscOn, !sl || kp);
      end
      $display("oscillator keep test done");
      summarize();
   end
endmodule
